// file: rtl/stp_pkg.sv
// Package with register map, field positions and timing counts of the shared timer prescaler.
package stp_pkg;

  // Wishbone byte offsets; general_timer_control sits at word index 0x23, four bytes per word.
  localparam logic [7:0] STP_GTC_INDEX    = 8'h23;
  localparam logic [9:0] STP_GTC_ADDR     = {STP_GTC_INDEX, 2'b00};
  localparam logic [9:0] STP_CLKSEL_ADDR  = 10'h000;
  localparam logic [9:0] STP_STATUS_ADDR  = 10'h004;
  localparam int         STP_ADDR_W       = 10;

  // Fields of general_timer_control.
  localparam int STP_SYNC_HOLD_BIT   = 7;
  localparam int STP_ASYNC_RST_BIT   = 1;
  localparam int STP_SYNC_RST_BIT    = 0;
  localparam logic [7:0] STP_GTC_RESET = 8'h00;

  // Fields of the clock select register: timer 0 in bits 2:0, timer 1 in bits 6:4.
  localparam int STP_SEL0_LSB = 0;
  localparam int STP_SEL1_LSB = 4;
  localparam int STP_SEL_W    = 3;
  localparam logic [7:0] STP_CLKSEL_RESET = 8'h00;

  // Clock select encodings.
  localparam logic [2:0] STP_SEL_STOP = 3'h0;
  localparam logic [2:0] STP_SEL_DIV1 = 3'h1;
  localparam logic [2:0] STP_SEL_D8   = 3'h2;
  localparam logic [2:0] STP_SEL_D64  = 3'h3;
  localparam logic [2:0] STP_SEL_D256 = 3'h4;
  localparam logic [2:0] STP_SEL_D1K  = 3'h5;
  localparam logic [2:0] STP_SEL_FALL = 3'h6;
  localparam logic [2:0] STP_SEL_RISE = 3'h7;

  // Prescaler: a 10-bit free running counter gives the four taps.
  localparam int          STP_PRE_W    = 10;
  localparam logic [9:0]  STP_MASK_D8   = 10'h007;
  localparam logic [9:0]  STP_MASK_D64  = 10'h03f;
  localparam logic [9:0]  STP_MASK_D256 = 10'h0ff;
  localparam logic [9:0]  STP_MASK_D1K  = 10'h3ff;

  // Number of timers sharing the prescaler.
  localparam int STP_NUM_TIMERS = 2;

endpackage

// file: rtl/stp_ext_edge.sv
// External count input sampler and edge detector for one timer.
`timescale 1ns/1ps
module stp_ext_edge (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Pin and selection
  input  wire logic       ext_count_input_i,
  input  wire logic [2:0] clock_source_select_i,
  // Pulses
  output logic            rise_o,
  output logic            fall_o
);

  logic sync1_ff;
  logic sync2_ff;
  logic prev_ff;

  // The transparent-high latch ahead of the flops is modelled by the first flop; a latch
  // would add a half-cycle but cannot be timed cleanly in a one-clock flop design.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1_ff <= 1'b0;
      sync2_ff <= 1'b0;
      prev_ff  <= 1'b0;
    end else begin
      sync1_ff <= ext_count_input_i;
      sync2_ff <= sync1_ff;
      prev_ff  <= sync2_ff;
    end
  end

  // Edges are only reported for the matching selection.
  always_comb begin
    rise_o = sync2_ff & ~prev_ff & (clock_source_select_i == stp_pkg::STP_SEL_RISE);
    fall_o = ~sync2_ff & prev_ff & (clock_source_select_i == stp_pkg::STP_SEL_FALL);
  end

endmodule

// file: rtl/stp_tap_sel.sv
// Count enable selector for one timer, choosing a prescaler tap or the pin edge.
`timescale 1ns/1ps
module stp_tap_sel (
  // Selection
  input  wire logic [2:0] clock_source_select_i,
  // Sources
  input  wire logic [3:0] taps_i,
  input  wire logic       edge_i,
  input  wire logic       halt_i,
  // Enable
  output logic            count_en_o
);

  always_comb begin
    unique case (clock_source_select_i)
      stp_pkg::STP_SEL_STOP: count_en_o = 1'b0;
      stp_pkg::STP_SEL_DIV1: count_en_o = ~halt_i;
      stp_pkg::STP_SEL_D8:   count_en_o = taps_i[0] & ~halt_i;
      stp_pkg::STP_SEL_D64:  count_en_o = taps_i[1] & ~halt_i;
      stp_pkg::STP_SEL_D256: count_en_o = taps_i[2] & ~halt_i;
      stp_pkg::STP_SEL_D1K:  count_en_o = taps_i[3] & ~halt_i;
      stp_pkg::STP_SEL_FALL: count_en_o = edge_i;
      stp_pkg::STP_SEL_RISE: count_en_o = edge_i;
    endcase
  end

endmodule

// file: rtl/stp_prescaler.sv
// Shared timer prescaler with pin edge detection and a Wishbone register slave.
//
// Operation
// - Selection one counts every system clock while the sync reset bit is clear.
// - Taps divide by 8, 64, 256, 1024.
// - One free running prescaler, independent per-timer selects.
// - First divided count after 1 to N+1 cycles.
// - Prescaler reset restarts period for both timers.
// - Pin sampled each cycle, then edge detected.
// - Sampling flops on rising edge, first flop in place of the latch.
// - Rising edge for seven, falling for six.
// - Pin edge to count takes 2-3 cycles.
// - External edges bypass the divider taps.
// - Sync hold mode keeps written reset bits.
// - Clearing hold mode clears both reset bits.
// - Writing sync reset bit resets prescaler, self-clears.
// - Selection zero gives no count clock.
`timescale 1ns/1ps
module stp_prescaler (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [9:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // External count pins, one per timer
  input  wire logic [1:0]  ext_count_input_i,
  // Count enables to the timers
  output logic      [1:0]  count_en_o,
  // Asynchronous prescaler reset request to the other prescaler
  output logic             async_prescaler_reset_o
);

  ////////////////////////////////////////////////////////////////////////////////
  // Register bus

  logic [7:0]  sel_reg_ff;
  logic        sync_hold_mode_ff;
  logic        async_prescaler_reset_ff;
  logic        sync_prescaler_reset_ff;
  logic        req;
  logic        wr_stb;
  logic        wr_gtc;
  logic        wr_sel;
  logic [31:0] nxt_dat;
  logic [9:0]  pre_cnt_ff;
  logic [3:0]  taps;

  // A request is served once; ack drops in the following cycle.
  assign req    = cyc_i & stb_i & ~ack_o;
  assign wr_stb = req & we_i & sel_i[0];
  assign wr_gtc = wr_stb & (adr_i == stp_pkg::STP_GTC_ADDR);
  assign wr_sel = wr_stb & (adr_i == stp_pkg::STP_CLKSEL_ADDR);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= req;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sel_reg_ff <= stp_pkg::STP_CLKSEL_RESET;
    end else if (wr_sel) begin
      sel_reg_ff <= dat_i[7:0] & 8'h77;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // General timer control

  // In hold mode the written reset bits stay set; otherwise they self-clear next cycle.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync_hold_mode_ff        <= stp_pkg::STP_GTC_RESET[stp_pkg::STP_SYNC_HOLD_BIT];
      async_prescaler_reset_ff <= stp_pkg::STP_GTC_RESET[stp_pkg::STP_ASYNC_RST_BIT];
      sync_prescaler_reset_ff  <= stp_pkg::STP_GTC_RESET[stp_pkg::STP_SYNC_RST_BIT];
    end else if (wr_gtc) begin
      sync_hold_mode_ff <= dat_i[stp_pkg::STP_SYNC_HOLD_BIT];
      if (dat_i[stp_pkg::STP_SYNC_HOLD_BIT]) begin
        // Writing a one sets; a zero leaves a held bit alone until hold mode ends.
        async_prescaler_reset_ff <= async_prescaler_reset_ff
                                    | dat_i[stp_pkg::STP_ASYNC_RST_BIT];
        sync_prescaler_reset_ff  <= sync_prescaler_reset_ff
                                    | dat_i[stp_pkg::STP_SYNC_RST_BIT];
      end else begin
        // Leaving hold mode releases both; a plain write gives a one-cycle reset pulse.
        async_prescaler_reset_ff <= dat_i[stp_pkg::STP_ASYNC_RST_BIT];
        sync_prescaler_reset_ff  <= dat_i[stp_pkg::STP_SYNC_RST_BIT];
      end
    end else if (!sync_hold_mode_ff) begin
      async_prescaler_reset_ff <= 1'b0;
      sync_prescaler_reset_ff  <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      async_prescaler_reset_o <= 1'b0;
    end else begin
      async_prescaler_reset_o <= async_prescaler_reset_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read data

  always_comb begin
    nxt_dat = 32'h0000_0000;
    unique case (adr_i)
      stp_pkg::STP_GTC_ADDR: begin
        nxt_dat[stp_pkg::STP_SYNC_HOLD_BIT] = sync_hold_mode_ff;
        nxt_dat[stp_pkg::STP_ASYNC_RST_BIT] = async_prescaler_reset_ff;
        nxt_dat[stp_pkg::STP_SYNC_RST_BIT]  = sync_prescaler_reset_ff;
      end
      stp_pkg::STP_CLKSEL_ADDR: nxt_dat[7:0] = sel_reg_ff;
      stp_pkg::STP_STATUS_ADDR: nxt_dat[11:0] = {count_en_o, pre_cnt_ff};
      default:                  nxt_dat = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h0000_0000;
    end else if (req & ~we_i) begin
      dat_o <= nxt_dat;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Shared prescaler


  // Never restarted by a timer select change, so the first divided count may come
  // anywhere from 1 to N+1 cycles after enabling.
  always_ff @(posedge clk_i) begin
    if (rst_i || sync_prescaler_reset_ff) begin
      pre_cnt_ff <= 10'h000;
    end else begin
      pre_cnt_ff <= pre_cnt_ff + 10'h001;
    end
  end

  // Each tap is high for one cycle per period, used as an enable, not a clock.
  assign taps[0] = (pre_cnt_ff & stp_pkg::STP_MASK_D8)   == stp_pkg::STP_MASK_D8;
  assign taps[1] = (pre_cnt_ff & stp_pkg::STP_MASK_D64)  == stp_pkg::STP_MASK_D64;
  assign taps[2] = (pre_cnt_ff & stp_pkg::STP_MASK_D256) == stp_pkg::STP_MASK_D256;
  assign taps[3] = (pre_cnt_ff & stp_pkg::STP_MASK_D1K)  == stp_pkg::STP_MASK_D1K;

  ////////////////////////////////////////////////////////////////////////////////
  // Per timer selection

  logic [1:0] nxt_count_en;

  // Changing the select only while the pin is steady avoids a false edge pulse.
  for (genvar t = 0; t < stp_pkg::STP_NUM_TIMERS; t++) begin : g_timer
    logic [2:0] sel;
    logic       rise;
    logic       fall;

    assign sel = sel_reg_ff[t*4 +: 3];

    stp_ext_edge u_edge (
      .clk_i                 (clk_i),
      .rst_i                 (rst_i),
      .ext_count_input_i     (ext_count_input_i[t]),
      .clock_source_select_i (sel),
      .rise_o                (rise),
      .fall_o                (fall)
    );

    // Held prescaler reset halts the timer on every internal source.
    stp_tap_sel u_sel (
      .clock_source_select_i (sel),
      .taps_i                (taps),
      .edge_i                (rise | fall),
      .halt_i                (sync_prescaler_reset_ff),
      .count_en_o            (nxt_count_en[t])
    );
  end

  // Registered enable: pin edge to count is two edges after the first sample.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_en_o <= 2'b00;
    end else begin
      count_en_o <= nxt_count_en;
    end
  end

endmodule

// file: tb/stp_prescaler_chk.sv
// Port checker of the shared timer prescaler.
`timescale 1ns/1ps
module stp_prescaler_chk (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [9:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  input  wire logic [31:0] dat_o,
  input  wire logic        ack_o,
  // Pins and enables
  input  wire logic [1:0]  ext_count_input_i,
  input  wire logic [1:0]  count_en_o,
  input  wire logic        async_prescaler_reset_o
);
  logic [2:0] sel0_ff;
  logic [2:0] sel1_ff;
  logic       held_ff;
  logic       wr;
  logic       gtc_wr;
  assign wr = cyc_i && stb_i && we_i && !ack_o && sel_i[0];
  assign gtc_wr = wr && adr_i == stp_pkg::STP_GTC_ADDR;
  // Selections are snooped from the bus so enables can be tied to them.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sel0_ff <= 3'h0;
      sel1_ff <= 3'h0;
    end else if (wr && adr_i == stp_pkg::STP_CLKSEL_ADDR) begin
      sel0_ff <= dat_i[2:0];
      sel1_ff <= dat_i[6:4];
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      held_ff <= 1'b0;
    end else if (gtc_wr) begin
      held_ff <= dat_i[7] && (held_ff || dat_i[0]);
    end
  end
  ////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence taken_s;
    cyc_i && stb_i && !ack_o;
  endsequence
  sequence answer_s;
    ##1 ack_o ##1 !ack_o;
  endsequence
  AST_ACK: assert property (taken_s |-> answer_s) else $error("ack not a one-cycle answer");
  AST_RST: assert property (disable iff (1'b0) rst_i |=> !ack_o && count_en_o == 2'b00)
    else $error("outputs active after reset");
  AST_UNMAP: assert property (ack_o && !we_i && adr_i != stp_pkg::STP_CLKSEL_ADDR &&
    adr_i != stp_pkg::STP_STATUS_ADDR && adr_i != stp_pkg::STP_GTC_ADDR |-> dat_o == 32'h0)
    else $error("unmapped read not zero");
  AST_GTC0:
    assert property (ack_o && !we_i && adr_i == stp_pkg::STP_GTC_ADDR |-> dat_o[0] == held_ff)
    else $error("sync reset bit wrong");
  AST_ASYNC:
    assert property (gtc_wr && dat_i[7] && dat_i[1] |-> ##[1:3] async_prescaler_reset_o)
    else $error("async reset not held");
  AST_STOP:
    assert property ($past(sel0_ff) == 3'h0 && $past(sel0_ff, 2) == 3'h0 |-> !count_en_o[0])
    else $error("count while stopped");
  AST_DIV1:
    assert property ($past(sel0_ff == 3'h1 && !held_ff) && $past(sel0_ff == 3'h1 && !held_ff, 2)
    && !$past(gtc_wr && dat_i[0], 2)
    |-> count_en_o[0]) else $error("missing undivided count");
  AST_D8:
    assert property (count_en_o[1] && sel1_ff == 3'h2 && $past(sel1_ff) == 3'h2
    |=> (!count_en_o[1] || sel1_ff != 3'h2) [*7]) else $error("divide by 8 too fast");
  AST_PIN:
    assert property (sel1_ff == 3'h7 && $rose(ext_count_input_i[1]) || sel1_ff == 3'h6 &&
    $fell(ext_count_input_i[1]) |-> ##[2:4] count_en_o[1]) else $error("pin edge lost");
endmodule
bind stp_prescaler stp_prescaler_chk chk_u (
  .clk_i                   (clk_i),
  .rst_i                   (rst_i),
  .cyc_i                   (cyc_i),
  .stb_i                   (stb_i),
  .we_i                    (we_i),
  .adr_i                   (adr_i),
  .sel_i                   (sel_i),
  .dat_i                   (dat_i),
  .dat_o                   (dat_o),
  .ack_o                   (ack_o),
  .ext_count_input_i       (ext_count_input_i),
  .count_en_o              (count_en_o),
  .async_prescaler_reset_o (async_prescaler_reset_o)
);

// file: tb/stp_ext_src.sv
// Model of the external clock source on the two count pins.
`timescale 1ns/1ps
module stp_ext_src (
  // Control
  input  wire logic       run_i,
  // Pins
  output logic      [1:0] pin_o
);
  // Half periods above 12.5 ns keep the rate under a 2.5th of the clock.
  initial pin_o = 2'b00;
  always #13 if (run_i) pin_o[0] <= ~pin_o[0];
  always #21 if (run_i) pin_o[1] <= ~pin_o[1];
endmodule

// file: tb/test_stp_prescaler.sv
// Bench of the shared timer prescaler.
`timescale 1ns/1ps
module test_stp_prescaler;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc_i = 1'b0;
  logic        stb_i = 1'b0;
  logic        we_i  = 1'b0;
  logic [9:0]  adr_i = 10'h000;
  logic [3:0]  sel_i = 4'h1;
  logic [31:0] dat_i = 32'h0;
  logic [31:0] dat_o;
  logic        ack_o;
  logic [1:0]  pin;
  logic [1:0]  count_en_o;
  logic        async_o;
  logic        run = 1'b0;
  logic [31:0] rd;
  logic [1:0]  pp;
  int          bad_count = 0;
  int          comparisons = 0;
  int          k;
  int          cn[6];
  int          exp_div[4] = '{128, 16, 4, 1};
  always #5 clk_i = ~clk_i;
  stp_prescaler dut_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .ext_count_input_i(pin), .count_en_o(count_en_o), .async_prescaler_reset_o(async_o));
  stp_ext_src src_u (.run_i(run), .pin_o(pin));
  ////////////////////////////////////////////////////////////
  task automatic stop_test;
    $display("Counts: %0d mismatches, %0d comparisons", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [9:0] a, input logic [7:0] d);
    int n = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= {24'h0, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    if (ack_o !== 1'b1) begin
      bad_count++;
      $display("ERROR %0t no bus answer", $time);
      stop_test;
    end else begin
      rd = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
    end
  endtask
  // Pins run for all but the last eight cycles so late edges still land in the count.
  task automatic cnt(input int n, input logic r);
    cn = '{default: 0};
    pp = pin;
    for (int j = 0; j < n; j++) begin
      run = r && (j < n - 8);
      @(posedge clk_i);
      #1;
      cn[0] += int'(count_en_o[0] === 1'b1);
      cn[1] += int'(count_en_o[1] === 1'b1);
      cn[2] += int'(!pp[0] && pin[0]);
      cn[3] += int'(pp[0] && !pin[0]);
      cn[4] += int'(!pp[1] && pin[1]);
      cn[5] += int'(pp[1] && !pin[1]);
      pp = pin;
    end
  endtask
  task automatic first;
    k = 0;
    do begin
      @(posedge clk_i);
      #1;
      k++;
    end while (count_en_o === 2'b00 && k < 2000);
    if (count_en_o === 2'b00) begin
      bad_count++;
      $display("ERROR %0t no count enable", $time);
      stop_test;
    end
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, stp_pkg::STP_GTC_ADDR, 8'h00);
    chk(rd, {24'h0, stp_pkg::STP_GTC_RESET});
    wb(1'b0, stp_pkg::STP_CLKSEL_ADDR, 8'h00);
    chk(rd, {24'h0, stp_pkg::STP_CLKSEL_RESET});
    wb(1'b0, 10'h010, 8'h00);
    chk(rd, 32'h0);
    cnt(64, 1'b0);
    chk(cn[0] + cn[1], 0);
    for (int i = 0; i < 4; i++) begin
      wb(1'b1, stp_pkg::STP_CLKSEL_ADDR, 8'(8'h21 + 16 * i));
      cnt(1024, 1'b0);
      chk(cn[0], 1024);
      chk(cn[1], exp_div[i]);
    end
    wb(1'b1, stp_pkg::STP_CLKSEL_ADDR, 8'h55);
    wb(1'b1, stp_pkg::STP_GTC_ADDR, 8'h01);
    wb(1'b0, stp_pkg::STP_GTC_ADDR, 8'h00);
    chk(rd, 32'h0);
    // Four cycles pass between the prescaler restart and the status read being taken.
    wb(1'b0, stp_pkg::STP_STATUS_ADDR, 8'h00);
    chk(rd, 32'h4);
    first();
    chk(count_en_o, 2'b11);
    chk(k >= 990 && k <= 1025, 1'b1);
    wb(1'b1, stp_pkg::STP_GTC_ADDR, 8'h83);
    wb(1'b0, stp_pkg::STP_GTC_ADDR, 8'h00);
    chk(rd, 32'h83);
    chk(async_o, 1'b1);
    cnt(1100, 1'b0);
    chk(cn[0] + cn[1], 0);
    wb(1'b1, stp_pkg::STP_GTC_ADDR, 8'h00);
    first();
    chk(count_en_o, 2'b11);
    wb(1'b0, stp_pkg::STP_GTC_ADDR, 8'h00);
    chk(rd, 32'h0);
    chk(async_o, 1'b0);
    for (int i = 0; i < 2; i++) begin
      wb(1'b1, stp_pkg::STP_CLKSEL_ADDR, i ? 8'h67 : 8'h76);
      cnt(400, 1'b1);
      chk(cn[0], i ? cn[2] : cn[3]);
      chk(cn[1], i ? cn[5] : cn[4]);
      chk(cn[4] > 10, 1'b1);
    end
    stop_test;
  end
endmodule
